// File: dv/scr_host_model.sv
// Bus host model that drives the two-wire clock and data for the slave.
`timescale 1ns/1ns
module scr_host_model (
  input  wire logic mclk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  // Both lines are released at time zero, so the bus idles high.
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // Every change lands on a falling system edge, well away from sampling.
  task automatic hold(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  // One bit slot of 12 cycles: data moves mid-low, is read mid-high.
  task automatic bit_slot(input logic b, output logic r);
    hold(3);
    sda_out = b;
    hold(3);
    scl_out = 1'b1;
    hold(3);
    r = sda_in;
    hold(3);
    scl_out = 1'b0;
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    hold(3);
    sda_out = 1'b1;
    hold(3);
    scl_out = 1'b1;
    hold(6);
    sda_out = 1'b0;
    hold(6);
    scl_out = 1'b0;
  endtask

  // Stop: data rises while the clock is high, leaving the bus free.
  task automatic stop();
    hold(3);
    sda_out = 1'b0;
    hold(3);
    scl_out = 1'b1;
    hold(6);
    sda_out = 1'b1;
    hold(6);
  endtask

  // Sends a byte most significant bit first, then reads the acknowledge.
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], r);
    end
    bit_slot(1'b1, r);
    ack = ~r;
  endtask

  // Reads a byte with the line released, then acknowledges if asked.
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, d[i]);
    end
    bit_slot(~ack, r);
  endtask
endmodule // scr_host_model

// File: dv/smbus_config_register_slave_tb.sv
// Self-checking bench for the two-wire configuration slave.
`timescale 1ns/1ns
module smbus_config_register_slave_tb import scr_pkg::*; ();
  localparam logic [7:0] IDENT = 8'h5A; // Arbitrary identity value.
  logic       mclk_in;          // System clock.
  logic       sys_rst_in;       // Synchronous reset.
  logic       apply_stall_in;   // Holds queued writes back.
  logic       scl;              // Host-driven bus clock.
  logic       host_sda;         // Host data drive, high means released.
  logic       pin_out;          // Device data value while enabled.
  logic       oe;               // Device pulls data while high.
  logic       queue_ready_out;  // Room left in the write queue.
  wire        sda_wire;         // Resolved wired-AND data line.
  scr_cfg_t   cfg_out;          // Decoded configuration fields.
  logic [7:0] shadow [0:8];     // Expected register bytes.
  int         num_errors;       // Mismatches seen.
  int         total_checks;     // Comparisons made.
  int         cycles = 0;       // Clock cycles since time zero.

  // The pull-up holds the line high unless some party pulls it low.
  assign sda_wire = host_sda & ~(oe & ~pin_out);

  scr_config_slave #(.IDENTITY(IDENT), .FIFO_DEPTH(32)) dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .serial_clock_pin_in(scl), .serial_data_pin_in(sda_wire),
    .serial_data_pin_out(pin_out), .serial_data_pin_oe_out(oe),
    .apply_stall_in(apply_stall_in), .queue_ready_out(queue_ready_out),
    .cfg_out(cfg_out));

  scr_host_model host (.mclk_in(mclk_in), .sda_in(sda_wire),
    .scl_out(scl), .sda_out(host_sda));

  // Builds the expected decoded fields from the expected bytes.
  function automatic scr_cfg_t cfg_of();
    scr_cfg_t c;
    c.bypass_select = shadow[3][7:5];
    c.vco_range     = shadow[6][7:5];
    c.loop1_ref_div = shadow[1];
    c.loop1_fb_div  = {shadow[3][3:0], shadow[2]};
    c.loop2_ref_div = {shadow[6][0], shadow[4]};
    c.loop2_fb_div  = {shadow[6][4:1], shadow[5]};
    c.loop3_ref_div = shadow[7];
    c.loop3_fb_div  = shadow[8];
    return c;
  endfunction

  // Case inequality, so an unknown never counts as a match.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Byte write; returns the acknowledge of the data byte.
  task automatic wr1(input logic [6:0] i, input logic [7:0] d,
                     output logic ack);
    logic a;
    host.start();
    host.send_byte(8'hD2, a);
    check(a, 1'b1);
    host.send_byte({1'b1, i}, a);
    check(a, 1'b1);
    host.send_byte(d, ack);
    host.stop();
  endtask

  // Byte read: command, repeated start, read address, one byte, NACK.
  task automatic rd1(input logic [6:0] i, output logic [7:0] d);
    logic a;
    host.start();
    host.send_byte(8'hD2, a);
    host.send_byte({1'b1, i}, a);
    host.start();
    host.send_byte(8'hD3, a);
    check(a, 1'b1);
    host.recv_byte(1'b0, d);
    host.stop();
  endtask

  // Power-up state with no programming at all.
  task automatic t_defaults();
    check(cfg_out, cfg_of());
    check(queue_ready_out, 1'b1);
    check(oe, 1'b0);
    $display("t_defaults done");
  endtask

  // Each register written alone; every other field must stay put.
  task automatic t_byte_write();
    logic a;
    logic [7:0] v;
    for (int i = 1; i <= 8; i++) begin
      v = {i[3:0], ~i[3:0]};
      wr1(i[6:0], v, a);
      shadow[i] = v;
      check(a, 1'b1);
      check(cfg_out, cfg_of());
    end
    $display("t_byte_write done");
  endtask

  // Read back, identity byte after a write to it, a refused second data byte, and past the map.
  task automatic t_byte_read();
    logic a;
    logic [7:0] d;
    wr1(7'h00, 8'hFF, a);
    rd1(7'h00, d);
    check(d, IDENT);
    // A second data byte in one single-byte write must be refused.
    host.start();
    host.send_byte(8'hD2, a);
    host.send_byte(8'h81, a);
    host.send_byte(8'h11, a);
    check(a, 1'b1);
    host.send_byte(8'h22, a);
    check(a, 1'b0);
    host.stop();
    shadow[1] = 8'h11;
    for (int i = 1; i <= 8; i++) begin
      rd1(i[6:0], d);
      check(d, shadow[i]);
    end
    rd1(7'h09, d);
    check(d, 8'h00);
    $display("t_byte_read done");
  endtask

  // A neighbouring address must draw no acknowledge and change nothing.
  task automatic t_foreign();
    logic a;
    host.start();
    host.send_byte(8'hD0, a);
    check(a, 1'b0);
    host.send_byte(8'h81, a);
    check(a, 1'b0);
    host.send_byte(8'hEE, a);
    check(a, 1'b0);
    host.stop();
    check(cfg_out, cfg_of());
    $display("t_foreign done");
  endtask

  // Block write of bytes 0..4, stopped early after a whole byte.
  task automatic t_block_write();
    logic a;
    logic [7:0] v;
    host.start();
    host.send_byte(8'hD2, a);
    host.send_byte(8'h00, a);
    check(a, 1'b1);
    host.send_byte(8'h00, a);
    for (int i = 1; i <= 4; i++) begin
      v = 8'hC0 | i[7:0];
      host.send_byte(v, a);
      check(a, 1'b1);
      shadow[i] = v;
    end
    host.stop();
    check(cfg_out, cfg_of());
    $display("t_block_write done");
  endtask

  // Block read of bytes 0..5; the identity byte reads as zero here.
  task automatic t_block_read();
    logic a;
    logic [7:0] d;
    host.start();
    host.send_byte(8'hD2, a);
    host.send_byte(8'h00, a);
    host.start();
    host.send_byte(8'hD3, a);
    check(a, 1'b1);
    for (int i = 0; i <= 5; i++) begin
      host.recv_byte(i != 5, d);
      check(d, (i == 0) ? 8'h00 : shadow[i]);
    end
    host.stop();
    $display("t_block_read done");
  endtask

  // Stalled queue fills to 32, refuses the next, then drains in order.
  task automatic t_queue_full();
    logic a;
    @(negedge mclk_in);
    apply_stall_in = 1'b1;
    for (int i = 0; i < 32; i++) begin
      wr1(7'h07, i[7:0], a);
      check(a, 1'b1);
    end
    check(queue_ready_out, 1'b0);
    wr1(7'h07, 8'hEE, a);
    check(a, 1'b0);
    check(cfg_out, cfg_of());
    @(negedge mclk_in);
    apply_stall_in = 1'b0;
    shadow[7] = 8'h1F;
    // Bounded wait for the drain to reach the last accepted byte.
    for (int n = 0; n < 200 && cfg_out !== cfg_of(); n++) begin
      @(negedge mclk_in);
    end
    check(cfg_out, cfg_of());
    check(queue_ready_out, 1'b1);
    $display("t_queue_full done");
  endtask

  // Free-running 250 MHz clock.
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  // Main sequence: three cycles of reset, then every scenario in turn.
  initial begin
    sys_rst_in = 1'b1;
    apply_stall_in = 1'b0;
    num_errors = 0;
    total_checks = 0;
    shadow = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01,
               8'h01};
    repeat (3) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    repeat (6) @(negedge mclk_in);
    t_defaults();
    t_byte_write();
    t_byte_read();
    t_foreign();
    t_block_write();
    t_block_read();
    t_queue_full();
    complete_run();
  end

  // Cuts a hang short; the tests need roughly 23000 cycles.
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      $display("[FAIL] t=%0t run timed out", $time);
      complete_run();
    end
  end
endmodule // smbus_config_register_slave_tb

// File: rtl/scr_config_slave.sv
// Two-wire configuration slave with its write queue and register bytes.
//
// Summary of operation
// R1: Behave as a standard two-wire management bus slave.
// R2: Accept byte write, byte read, block write, read.
// R3: Block bytes ascend from lowest; bits MSB first.
// R4: Host may stop after any complete byte.
// R5: Single-byte access touches only the indexed register.
// R6: Written byte takes effect at acknowledge rising edge; code queues it then, applies it on a later pop.
// R7: Answer only address 1101001; write bit is zero.
// R8: Command bit 7 picks block or single access.
// R9: Command bits 6:0 index single-byte register.
// R10: Host writes only zero into byte zero.
// R11: Registers load defaults at power-up.
// R12: Loop one reference divider low byte in byte 1.
// R13: Loop one feedback divider spans bytes 2 and 3.
// R14: Byte zero readable only by single-byte read.
// R15: Configuration bytes are readable and writable.
// R16: Block transfers start at zero, step by one.
// R17: Ignore and never acknowledge a foreign address.
`timescale 1ns/1ns
`include "scr_map.svh"

// Write queue: parameterised FIFO with valid and ready on both sides.
module scr_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];  // Storage words.
  logic [AW:0]      wr_ptr;           // Write pointer with wrap bit.
  logic [AW:0]      rd_ptr;           // Read pointer with wrap bit.
  logic             full;             // Every word holds data.
  logic             empty;            // No word holds data.
  logic             push;             // Word accepted this cycle.
  logic             pop;              // Word delivered this cycle.
  assign full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                 (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign push  = in_valid_in && !full;
  assign pop   = out_ready_in && !empty;
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem[rd_ptr[AW-1:0]];
  // Storage is not reset; the pointers alone define what is valid.
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end
  // Pointer advance on each accepted and delivered word.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // scr_fifo

// Serial slave, register bytes and decoded configuration outputs.
module scr_config_slave import scr_pkg::*; #(
  parameter logic [7:0] IDENTITY   = 8'h5A,  // Arbitrary identity value.
  parameter int         FIFO_DEPTH = 32
) (
  input  wire logic     mclk_in,
  input  wire logic     sys_rst_in,
  input  wire logic     serial_clock_pin_in,
  input  wire logic     serial_data_pin_in,
  output logic          serial_data_pin_out,
  output logic          serial_data_pin_oe_out,
  input  wire logic     apply_stall_in,
  output logic          queue_ready_out,
  output scr_cfg_t      cfg_out
);
  localparam int REQ_W = $bits(scr_wr_req_t);
  localparam int NREG  = 8;
  // Packed power-up image of bytes 1 through 8.
  localparam logic [8*NREG-1:0] DEF_VEC = {
    `SCR_DEF_LOOP3_FB_DIV_LOW,         `SCR_DEF_LOOP3_REF_DIV_LOW,
    `SCR_DEF_VCO_RANGE_LOOP2_DIV_HIGH, `SCR_DEF_LOOP2_FB_DIV_LOW,
    `SCR_DEF_LOOP2_REF_DIV_LOW,        `SCR_DEF_BYPASS_MUX_LOOP1_FB_HIGH,
    `SCR_DEF_LOOP1_FB_DIV_LOW,         `SCR_DEF_LOOP1_REF_DIV_LOW};
  logic        scl_s1;          // Clock pin, first sync stage.
  logic        scl_s2;          // Clock pin, second sync stage.
  logic        scl_d;           // Clock pin, delayed for edges.
  logic        sda_s1;          // Data pin, first sync stage.
  logic        sda_s2;          // Data pin, second sync stage.
  logic        sda_d;           // Data pin, delayed for edges.
  logic        scl_rise;        // Serial clock rising edge.
  logic        scl_fall;        // Serial clock falling edge.
  logic        start_ev;        // Start or repeated start seen.
  logic        stop_ev;         // Stop seen.
  logic        byte_done;       // Eighth bit has been clocked in.
  logic [7:0]  next_shift_in;   // Shift register with new bit.
  scr_state_t  state;           // Protocol state.
  logic [3:0]  bit_cnt;         // Bits seen in this byte.
  logic [7:0]  shift;           // Serial shift register.
  logic [6:0]  idx;             // Current register index.
  logic        single_mode;     // Command selected single-byte access.
  logic        rd_mode;         // Address phase asked for a read.
  logic        single_done;     // Single-byte write already stored.
  logic        drive_low;       // Pull the data line low.
  logic        wr_accept;       // This write byte will be acknowledged.
  logic        push;            // Queue a received byte.
  logic        q_ready;         // Queue has room.
  logic        q_valid;         // Queue holds a byte to apply.
  logic        pop;             // Byte applied this cycle.
  scr_wr_req_t push_req;        // Byte entering the queue.
  scr_wr_req_t pop_req;         // Byte leaving the queue.
  logic        in_map;          // Index falls on a writable byte.
  logic [7:0]  rd_byte;         // Byte to shift out at the index.
  logic [7:0]  cfg_regs [1:NREG];  // Writable register bytes.

  // Two-stage synchronisers, then a third stage for edge detection.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= serial_clock_pin_in;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= serial_data_pin_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  // Line events; data edges while the clock stays high frame a transfer.
  assign scl_rise  = scl_s2 && !scl_d;
  assign scl_fall  = !scl_s2 && scl_d;
  assign start_ev  = scl_s2 && scl_d && sda_d && !sda_s2;   // R1
  assign stop_ev   = scl_s2 && scl_d && !sda_d && sda_s2;   // R1
  assign byte_done = scl_fall && (bit_cnt == `SCR_BYTE_BITS);
  assign next_shift_in = {shift[6:0], sda_s2};              // R3
  // Byte zero reads as identity only on a single-byte read.
  assign in_map  = (idx != `SCR_IDENTITY_REVISION) &&
                   (idx <= `SCR_LOOP3_FB_DIV_LOW);
  assign rd_byte = (idx == `SCR_IDENTITY_REVISION) ?
                   (single_mode ? IDENTITY : `SCR_BLOCK_ID_FILL) :  // R14
                   (in_map ? cfg_regs[idx[3:0]] : 8'h00);           // R15
  // A full queue or a second single-byte write is refused with no ack.
  assign wr_accept = q_ready && !(single_mode && single_done);      // R5
  // Store at the rising clock edge of the acknowledge bit.
  assign push      = (state == SCR_WACK) && scl_rise && drive_low;  // R6
  assign push_req  = '{idx: idx, data: shift};
  // Serial protocol engine; the line changes only after a clock fall.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state       <= SCR_IDLE;
      bit_cnt     <= 4'h0;
      shift       <= 8'h00;
      idx         <= 7'h00;
      single_mode <= 1'b0;
      rd_mode     <= 1'b0;
      single_done <= 1'b0;
      drive_low   <= 1'b0;
    end else if (stop_ev) begin
      // Completed bytes are already queued, so a stop loses nothing.
      state     <= SCR_IDLE;  // R4
      drive_low <= 1'b0;
    end else if (start_ev) begin
      // Index and mode survive a repeated start for the read phase.
      state     <= SCR_ADDR;
      bit_cnt   <= 4'h0;
      drive_low <= 1'b0;
    end else begin
      case (state)
        SCR_ADDR: begin
          if (scl_rise) begin
            shift   <= next_shift_in;
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            if (shift[7:1] == `SCR_SLAVE_ADDR) begin  // R7
              state     <= SCR_AACK;
              drive_low <= 1'b1;
              rd_mode   <= shift[0];
            end else begin
              state <= SCR_IDLE;  // R17
            end
          end
        end
        SCR_AACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (rd_mode) begin
              state     <= SCR_RDATA;  // R2
              shift     <= rd_byte;
              drive_low <= !rd_byte[7];  // R3
            end else begin
              state     <= SCR_CMD;
              drive_low <= 1'b0;
            end
          end
        end
        SCR_CMD: begin
          if (scl_rise) begin
            shift   <= next_shift_in;
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            state       <= SCR_CACK;
            drive_low   <= 1'b1;
            single_done <= 1'b0;
            single_mode <= shift[`SCR_CMD_SINGLE_BIT];  // R8
            if (shift[`SCR_CMD_SINGLE_BIT]) begin
              idx <= shift[6:0];  // R9
            end else begin
              idx <= 7'h00;  // R16
            end
          end
        end
        SCR_CACK: begin
          if (scl_fall) begin
            state     <= SCR_WDATA;
            bit_cnt   <= 4'h0;
            drive_low <= 1'b0;
          end
        end
        SCR_WDATA: begin
          if (scl_rise) begin
            shift   <= next_shift_in;
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            state     <= SCR_WACK;
            drive_low <= wr_accept;  // R5
          end
        end
        SCR_WACK: begin
          if (push) begin
            idx         <= idx + 7'h01;  // R16
            single_done <= single_mode;  // R5
          end
          if (scl_fall) begin
            state     <= SCR_WDATA;
            bit_cnt   <= 4'h0;
            drive_low <= 1'b0;
          end
        end
        SCR_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == `SCR_LAST_BIT) begin
              state     <= SCR_RACK;
              bit_cnt   <= 4'h0;
              drive_low <= 1'b0;
            end else begin
              shift     <= {shift[6:0], 1'b0};
              drive_low <= !shift[6];  // R3
              bit_cnt   <= bit_cnt + 4'h1;
            end
          end
        end
        SCR_RACK: begin
          if (scl_rise) begin
            if (sda_s2) begin
              state <= SCR_IDLE;  // R4
            end else if (!single_mode) begin
              idx <= idx + 7'h01;  // R16
            end
          end else if (scl_fall) begin
            state     <= SCR_RDATA;
            shift     <= rd_byte;
            drive_low <= !rd_byte[7];
          end
        end
        SCR_IDLE: begin
          drive_low <= 1'b0;
        end
        default: begin
          state     <= SCR_IDLE;
          drive_low <= 1'b0;
        end
      endcase
    end
  end
  // Open-drain data pin: the level driven is always low.
  assign serial_data_pin_out    = 1'b0;
  assign serial_data_pin_oe_out = drive_low;
  assign queue_ready_out        = q_ready;
  // Queue between the serial side and the register bytes.
  scr_fifo #(
    .WIDTH (REQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .mclk_in       (mclk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (push),
    .in_ready_out  (q_ready),
    .in_data_in    (push_req),
    .out_valid_out (q_valid),
    .out_ready_in  (!apply_stall_in),
    .out_data_out  (pop_req)
  );
  // A stall holds bytes in the queue; new writes are nacked once full.
  assign pop = q_valid && !apply_stall_in;
  // One writable byte per index; byte zero has no storage to write.
  for (genvar i = 1; i <= NREG; i++) begin : g_reg
    always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
        cfg_regs[i] <= DEF_VEC[i*8-8 +: 8];  // R11
      end else if (pop && (pop_req.idx == 7'(i))) begin
        cfg_regs[i] <= pop_req.data;  // R15
      end
    end
  end
  // Field map of the register bytes onto the core controls.
  assign cfg_out.bypass_select = cfg_regs[3][7:5];
  assign cfg_out.vco_range     = cfg_regs[6][7:5];
  assign cfg_out.loop1_ref_div = cfg_regs[1];  // R12
  assign cfg_out.loop1_fb_div  = {cfg_regs[3][3:0], cfg_regs[2]};  // R13
  assign cfg_out.loop2_ref_div = {cfg_regs[6][0], cfg_regs[4]};
  assign cfg_out.loop2_fb_div  = {cfg_regs[6][4:1], cfg_regs[5]};
  assign cfg_out.loop3_ref_div = cfg_regs[7];
  assign cfg_out.loop3_fb_div  = cfg_regs[8];
  // Checks on the protocol engine and register update path.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  a_addr_match: assert property ( // R17
    (state == SCR_AACK) |-> (shift[7:1] == `SCR_SLAVE_ADDR))
    else $error("Acknowledged a foreign address.");
  a_push_edge: assert property ( // R6
    push |-> !$past(scl_s2) ##1 q_valid)
    else $error("Write not queued at the acknowledge rise.");
  a_block_step: assert property ( // R16
    (push && !single_mode) |=> (idx == $past(idx) + 7'h01))
    else $error("Block index did not step by one.");
  a_single_once: assert property ( // R5
    (push && single_mode) |=> !push [*2] ##0 single_done)
    else $error("Single-byte write stored more than once.");
  a_cmd_index: assert property ( // R9
    $rose(state == SCR_CACK) |->
      (idx == (shift[7] ? shift[6:0] : 7'h00)) &&
      (single_mode == shift[7]))
    else $error("Command byte decoded to the wrong index.");
  a_block_hide: assert property ( // R14
    ($rose(state == SCR_RDATA) && (idx == 7'h00) && !single_mode)
      |-> (shift == `SCR_BLOCK_ID_FILL))
    else $error("Identity byte leaked in a block read.");
  a_msb_first: assert property ( // R3
    (state == SCR_RDATA) |-> (drive_low == !shift[7]))
    else $error("Read bit on the line is not the top bit.");
  a_reg_update: assert property ( // R15
    (pop && (pop_req.idx == 7'h02)) |=> (cfg_regs[2] == $past(pop_req.data))
      ##0 (cfg_out.loop1_fb_div[7:0] == cfg_regs[2]))
    else $error("Queued byte did not reach its register.");
  a_ack_release: assert property ( // R1
    (state == SCR_WACK) && scl_fall |=> !drive_low ##1 !drive_low)
    else $error("Data line held after the acknowledge bit.");
endmodule // scr_config_slave

// File: rtl/scr_map.svh
// Register offsets, bus constants and power-up values for the config slave.
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// Fixed 7-bit slave address, binary 1101001.
`define SCR_SLAVE_ADDR      7'h69
// Command byte: bit that selects single-byte access.
`define SCR_CMD_SINGLE_BIT  7
// Number of bits in one serial byte.
`define SCR_BYTE_BITS       4'h8
// Last bit index inside a byte while shifting out.
`define SCR_LAST_BIT        4'h7

// Register byte offsets.
`define SCR_IDENTITY_REVISION         7'h00
`define SCR_LOOP1_REF_DIV_LOW         7'h01
`define SCR_LOOP1_FB_DIV_LOW          7'h02
`define SCR_BYPASS_MUX_LOOP1_FB_HIGH  7'h03
`define SCR_LOOP2_REF_DIV_LOW         7'h04
`define SCR_LOOP2_FB_DIV_LOW          7'h05
`define SCR_VCO_RANGE_LOOP2_DIV_HIGH  7'h06
`define SCR_LOOP3_REF_DIV_LOW         7'h07
`define SCR_LOOP3_FB_DIV_LOW          7'h08

// Power-up values of the writable bytes.
`define SCR_DEF_LOOP1_REF_DIV_LOW         8'h01
`define SCR_DEF_LOOP1_FB_DIV_LOW          8'h01
`define SCR_DEF_BYPASS_MUX_LOOP1_FB_HIGH  8'h00
`define SCR_DEF_LOOP2_REF_DIV_LOW         8'h01
`define SCR_DEF_LOOP2_FB_DIV_LOW          8'h01
`define SCR_DEF_VCO_RANGE_LOOP2_DIV_HIGH  8'h00
`define SCR_DEF_LOOP3_REF_DIV_LOW         8'h01
`define SCR_DEF_LOOP3_FB_DIV_LOW          8'h01

// Value a block read returns in place of the identity byte.
`define SCR_BLOCK_ID_FILL  8'h00

`endif

// File: rtl/scr_pkg.sv
// Types shared by the configuration slave and its write queue.
package scr_pkg;

  // One-hot serial protocol states.
  typedef enum logic [8:0] {
    SCR_IDLE  = 9'h001,
    SCR_ADDR  = 9'h002,
    SCR_AACK  = 9'h004,
    SCR_CMD   = 9'h008,
    SCR_CACK  = 9'h010,
    SCR_WDATA = 9'h020,
    SCR_WACK  = 9'h040,
    SCR_RDATA = 9'h080,
    SCR_RACK  = 9'h100
  } scr_state_t;

  // One received register write on its way to the register file.
  typedef struct packed {
    logic [6:0] idx;
    logic [7:0] data;
  } scr_wr_req_t;

  // Decoded configuration fields presented to the synthesizer core.
  typedef struct packed {
    logic [2:0]  bypass_select;   // Loop 1, 2, 3 bypass selects.
    logic [2:0]  vco_range;       // Loop 1, 2, 3 oscillator range.
    logic [7:0]  loop1_ref_div;   // Low eight bits of a 9-bit divider.
    logic [11:0] loop1_fb_div;
    logic [8:0]  loop2_ref_div;
    logic [11:0] loop2_fb_div;
    logic [7:0]  loop3_ref_div;   // Low eight bits of a 9-bit divider.
    logic [7:0]  loop3_fb_div;    // Low eight bits of a 12-bit divider.
  } scr_cfg_t;

endpackage
